//--- logic/bus_transceiver.sv
// 18-bit universal bus transceiver with APB status and capture log
//
// Contract
// - Eighteen identical independent data bits carried in each direction.
// - A-to-B latch enable high passes A straight to B.
// - Latch enable low, clock steady: stored value held, A changes ignored.
// - Latch enable low: rising A-to-B clock stores A and presents it.
// - B outputs driven only while A-to-B output enable is high.
// - A-to-B output enable low puts every B output in high impedance.
// - B-to-A flow behaves alike with its own enable, latch and clock.
// - B-to-A output enable is active low.
// - Latch enable falling with clock high keeps the earlier output level.
// - Undriven data inputs are held at their last valid level.
`timescale 1ns/100ps
module bus_transceiver #(
    parameter int WIDTH = xcvr_pkg::DATA_W,
    parameter int LOG_DEPTH = xcvr_pkg::FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [xcvr_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [xcvr_pkg::APB_W-1:0] pwdata,
    output logic [xcvr_pkg::APB_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WIDTH-1:0] a_in,
    output logic [WIDTH-1:0] a_out,
    output logic [WIDTH-1:0] a_oe,
    input wire logic [WIDTH-1:0] b_in,
    output logic [WIDTH-1:0] b_out,
    output logic [WIDTH-1:0] b_oe,
    input wire logic a_to_b_output_enable,
    input wire logic a_to_b_latch_enable,
    input wire logic a_to_b_clock,
    input wire logic b_to_a_output_enable_n,
    input wire logic b_to_a_latch_enable,
    input wire logic b_to_a_clock,
    output logic [WIDTH-1:0] a_keep,
    output logic [WIDTH-1:0] b_keep
);
    import xcvr_pkg::*;

    typedef struct packed {
        logic [1:0] log_en;
        logic ovf;
        logic [WIDTH-1:0] a_keep;
        logic [WIDTH-1:0] b_keep;
        logic [APB_W-1:0] rdata;
        logic slverr;
    } top_state_t;

    top_state_t s_q, s_d;
    lane_ctrl_t ab_ctrl, ba_ctrl;
    logic [WIDTH-1:0] ab_data, ba_data;
    logic ab_cap, ba_cap;
    lane_mode_t ab_mode, ba_mode;
    logic log_ab, log_ba;
    logic push_valid, push_ready;
    log_word_t push_word, head_word;
    logic head_valid, pop_ready;
    logic setup, access, wr_access;

    if (WIDTH < 1 || WIDTH > LOG_DIR_BIT) begin : g_bad_width
        $error("bus_transceiver: WIDTH must lie between 1 and 18");
    end

    // Address decode for the error answer; the read path decodes with its own case
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        reg_hit = addr == CTRL_OFS || addr == STATUS_OFS || addr == HELD_AB_OFS
            || addr == HELD_BA_OFS || addr == LOG_OFS;
    endfunction

    // Zero-extend a lane value into a bus word
    function automatic logic [APB_W-1:0] widen(input logic [WIDTH-1:0] v);
        widen = '0;
        widen[WIDTH-1:0] = v;
    endfunction

    // Control pins grouped per direction; B-to-A enable inverted here
    assign ab_ctrl = '{oe: a_to_b_output_enable, latch_en: a_to_b_latch_enable,
        clock: a_to_b_clock};
    assign ba_ctrl = '{oe: !b_to_a_output_enable_n, latch_en: b_to_a_latch_enable,
        clock: b_to_a_clock};

    xfer_lane #(
        .WIDTH(WIDTH)
    ) u_lane_ab (
        .pclk(pclk),
        .presetn(presetn),
        .data_in(a_in),
        .ctrl(ab_ctrl),
        .data_q(ab_data),
        .capture(ab_cap),
        .mode(ab_mode)
    );

    xfer_lane #(
        .WIDTH(WIDTH)
    ) u_lane_ba (
        .pclk(pclk),
        .presetn(presetn),
        .data_in(b_in),
        .ctrl(ba_ctrl),
        .data_q(ba_data),
        .capture(ba_cap),
        .mode(ba_mode)
    );

    // Pin drive: data always from the store, enable gates the driver
    assign b_out = ab_data;
    assign b_oe = {WIDTH{ab_ctrl.oe}};
    assign a_out = ba_data;
    assign a_oe = {WIDTH{ba_ctrl.oe}};

    // Capture log: clocked stores are queued for software
    assign log_ab = s_q.log_en[CTRL_LOG_AB_BIT] && ab_cap;
    assign log_ba = s_q.log_en[CTRL_LOG_BA_BIT] && ba_cap;
    assign push_valid = log_ab || log_ba;
    always_comb begin
        push_word = '0;
        if (log_ab) begin
            push_word.dir = DIR_AB;
            push_word.data[WIDTH-1:0] = a_in;
        end else begin
            push_word.dir = DIR_BA;
            push_word.data[WIDTH-1:0] = b_in;
        end
    end

    log_fifo #(
        .WIDTH($bits(log_word_t)),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(head_valid),
        .out_ready(pop_ready),
        .out_data(head_word)
    );

    // APB phases
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_access = access && pwrite;
    assign pop_ready = access && !pwrite && paddr == LOG_OFS;
    assign pready = 1'b1;

    always_comb begin
        s_d = s_q;
        // Bus hold: the keeper follows whatever level is on each port
        s_d.a_keep = ba_ctrl.oe ? a_out : a_in;
        s_d.b_keep = ab_ctrl.oe ? b_out : b_in;
        if (wr_access && paddr == CTRL_OFS) begin
            s_d.log_en = pwdata[1:0];
        end
        if (wr_access && paddr == STATUS_OFS && pwdata[STATUS_OVF_BIT]) begin
            s_d.ovf = 1'b0;
        end
        // Lost capture wins over a clear in the same cycle
        if ((log_ab && log_ba) || (push_valid && !push_ready)) begin
            s_d.ovf = 1'b1;
        end
        if (setup) begin
            s_d.slverr = !reg_hit(paddr);
            s_d.rdata = '0;
            case (paddr)
                CTRL_OFS: begin
                    s_d.rdata[1:0] = s_q.log_en;
                end
                STATUS_OFS: begin
                    s_d.rdata[STATUS_VALID_BIT] = head_valid;
                    s_d.rdata[STATUS_OVF_BIT] = s_q.ovf;
                    s_d.rdata[STATUS_MODE_AB_LSB +: 3] = ab_mode;
                    s_d.rdata[STATUS_MODE_BA_LSB +: 3] = ba_mode;
                end
                HELD_AB_OFS: begin
                    s_d.rdata = widen(ab_data);
                end
                HELD_BA_OFS: begin
                    s_d.rdata = widen(ba_data);
                end
                LOG_OFS: begin
                    if (head_valid) begin
                        s_d.rdata[LOG_DIR_BIT:0] = head_word;
                        s_d.rdata[LOG_VALID_BIT] = 1'b1;
                    end
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{log_en: CTRL_RST, ovf: 1'b0, a_keep: DATA_RST[WIDTH-1:0],
                b_keep: DATA_RST[WIDTH-1:0], rdata: '0, slverr: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pslverr = s_q.slverr;
    assign a_keep = s_q.a_keep;
    assign b_keep = s_q.b_keep;

    // Checks on the transfer behaviour and the sticky overflow flag
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_AB_PASS:
    assert property (a_to_b_latch_enable |=> b_out == $past(a_in))
        else $error("A-to-B transparent path did not follow A");

    AST_AB_HOLD:
    assert property (!a_to_b_latch_enable && $stable(a_to_b_clock)
        ##1 !a_to_b_latch_enable && $stable(a_to_b_clock) |=> $stable(b_out))
        else $error("A-to-B store changed while latched");

    AST_AB_CLOCKED:
    assert property ($past(presetn) && !a_to_b_latch_enable && $rose(a_to_b_clock)
        |=> b_out == $past(a_in) && ab_mode == MODE_CLOCK)
        else $error("A-to-B rising clock did not store A");

    AST_B_DRIVE:
    assert property (a_to_b_output_enable |-> b_oe == {WIDTH{1'b1}})
        else $error("B port not driven while enabled");

    AST_B_FLOAT:
    assert property (!a_to_b_output_enable |-> b_oe == '0)
        else $error("B port driven while disabled");

    AST_BA_PASS:
    assert property (b_to_a_latch_enable |=> a_out == $past(b_in)
        && ba_mode == MODE_PASS)
        else $error("B-to-A transparent path did not follow B");

    AST_BA_CLOCKED:
    assert property ($past(presetn) && !b_to_a_latch_enable && $rose(b_to_a_clock)
        |=> a_out == $past(b_in))
        else $error("B-to-A rising clock did not store B");

    AST_A_DRIVE_LOW:
    assert property (a_oe == {WIDTH{!b_to_a_output_enable_n}})
        else $error("A port enable has wrong polarity");

    AST_LE_FALL_CLK_HIGH:
    assert property ($fell(a_to_b_latch_enable) && a_to_b_clock && $past(a_to_b_clock)
        ##1 (a_to_b_clock && !a_to_b_latch_enable)[*3]
        |-> b_out == $past(b_out, 3))
        else $error("Output moved after latch closed with clock high");

    AST_KEEPER:
    assert property (!b_to_a_output_enable_n |=> a_keep == $past(a_out))
        else $error("A keeper lost the driven level");

    AST_HIDDEN_UPDATE:
    assert property (!a_to_b_output_enable && a_to_b_latch_enable
        ##1 !a_to_b_output_enable |-> b_out == $past(a_in))
        else $error("A-to-B store froze while outputs floated");

    AST_OVF_STICKY:
    assert property (s_q.ovf && !(wr_access && paddr == STATUS_OFS) |=> s_q.ovf)
        else $error("Overflow flag dropped without a clear");

    AST_BA_HOLD:
    assert property (!b_to_a_latch_enable && $stable(b_to_a_clock)
        ##1 !b_to_a_latch_enable && $stable(b_to_a_clock) |=> $stable(a_out))
        else $error("B-to-A store changed while latched");

    AST_BA_MODE_HOLD:
    assert property (!b_to_a_latch_enable && !$rose(b_to_a_clock)
        |=> ba_mode == MODE_HOLD)
        else $error("B-to-A mode not hold while latched");

    AST_BA_MODE_CLOCK:
    assert property ($past(presetn) && !b_to_a_latch_enable && $rose(b_to_a_clock)
        |=> ba_mode == MODE_CLOCK)
        else $error("B-to-A mode not clocked after a rising clock");

    AST_A_DRIVE:
    assert property (!b_to_a_output_enable_n |-> a_oe == {WIDTH{1'b1}})
        else $error("A port not driven while enabled");

    AST_A_FLOAT:
    assert property (b_to_a_output_enable_n |-> a_oe == '0)
        else $error("A port driven while disabled");

    AST_AB_MODE_PASS:
    assert property (a_to_b_latch_enable |=> ab_mode == MODE_PASS)
        else $error("A-to-B mode not pass while transparent");

    AST_AB_MODE_HOLD:
    assert property (!a_to_b_latch_enable && !$rose(a_to_b_clock)
        |=> ab_mode == MODE_HOLD)
        else $error("A-to-B mode not hold while latched");

    AST_B_KEEPER:
    assert property (a_to_b_output_enable |=> b_keep == $past(b_out))
        else $error("B keeper lost the driven level");

    AST_B_KEEPER_FLOAT:
    assert property (!a_to_b_output_enable |=> b_keep == $past(b_in))
        else $error("B keeper did not follow the floating port");

    AST_A_KEEPER_FLOAT:
    assert property (b_to_a_output_enable_n |=> a_keep == $past(a_in))
        else $error("A keeper did not follow the floating port");

    // Register bus and capture log
    AST_ERR_READS_ZERO:
    assert property (access && pslverr |-> prdata == '0)
        else $error("Unmapped access returned data");

    AST_ERR_WRITE_IGNORED:
    assert property (wr_access && pslverr |=> $stable(s_q.log_en))
        else $error("Unmapped write changed the control bits");

    AST_CTRL_WRITE:
    assert property (wr_access && paddr == CTRL_OFS
        |=> s_q.log_en == $past(pwdata[1:0]))
        else $error("Control write did not land");

    AST_OVF_SET:
    assert property (push_valid && !push_ready |=> s_q.ovf)
        else $error("Lost capture did not raise overflow");

    AST_OVF_CLEAR:
    assert property (wr_access && paddr == STATUS_OFS && pwdata[STATUS_OVF_BIT]
        && !push_valid |=> !s_q.ovf)
        else $error("Overflow flag not cleared by a write of one");

    AST_LOG_EMPTY_READ:
    assert property (setup && paddr == LOG_OFS && !head_valid |=> prdata == '0)
        else $error("Empty log read returned data");
endmodule // bus_transceiver

//--- logic/log_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module log_fifo #(
    parameter int WIDTH = xcvr_pkg::DATA_W + 1,
    parameter int DEPTH = xcvr_pkg::FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import xcvr_pkg::*;
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] count;
    } fifo_state_t;

    fifo_state_t s_q, s_d;
    logic push, pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("log_fifo: DEPTH must be a power of two, at least 2");
    end

    assign in_ready = s_q.count != DEPTH[PW:0];
    assign out_valid = s_q.count != '0;
    assign out_data = s_q.mem[s_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.count = s_q.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // log_fifo

//--- logic/xcvr_pkg.sv
// Shared constants and types for the 18-bit universal bus transceiver
package xcvr_pkg;
    localparam int DATA_W = 18;
    localparam int FIFO_DEPTH = 4;
    localparam int ADDR_W = 8;
    localparam int APB_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] HELD_AB_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] HELD_BA_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] LOG_OFS = 8'h10;
    localparam int CTRL_LOG_AB_BIT = 0;
    localparam int CTRL_LOG_BA_BIT = 1;
    localparam int STATUS_VALID_BIT = 0;
    localparam int STATUS_OVF_BIT = 1;
    localparam int STATUS_MODE_AB_LSB = 4;
    localparam int STATUS_MODE_BA_LSB = 8;
    localparam int LOG_VALID_BIT = 31;
    localparam int LOG_DIR_BIT = 18;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic CLK_PREV_RST = 1'b1;
    localparam logic DIR_AB = 1'b0;
    localparam logic DIR_BA = 1'b1;

    typedef enum logic [2:0] {
        MODE_PASS = 3'h1,
        MODE_HOLD = 3'h2,
        MODE_CLOCK = 3'h4
    } lane_mode_t;

    typedef struct packed {
        logic oe;
        logic latch_en;
        logic clock;
    } lane_ctrl_t;

    typedef struct packed {
        logic dir;
        logic [DATA_W-1:0] data;
    } log_word_t;
endpackage

//--- logic/xfer_lane.sv
// One direction of the transceiver: transparent, latched or clocked store
`timescale 1ns/100ps
module xfer_lane #(
    parameter int WIDTH = xcvr_pkg::DATA_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] data_in,
    input wire xcvr_pkg::lane_ctrl_t ctrl,
    output logic [WIDTH-1:0] data_q,
    output logic capture,
    output xcvr_pkg::lane_mode_t mode
);
    import xcvr_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] data;
        logic clk_prev;
        lane_mode_t mode;
    } lane_state_t;

    lane_state_t s_q, s_d;
    logic rise;

    if (WIDTH < 1 || WIDTH > DATA_W) begin : g_bad_width
        $error("xfer_lane: WIDTH must lie between 1 and 18");
    end

    assign rise = ctrl.clock && !s_q.clk_prev;
    // Clocked store only counts while the latch is closed
    assign capture = !ctrl.latch_en && rise;

    always_comb begin
        s_d = s_q;
        s_d.clk_prev = ctrl.clock;
        case (1'b1)
            ctrl.latch_en: begin
                s_d.data = data_in;
                s_d.mode = MODE_PASS;
            end
            rise: begin
                s_d.data = data_in;
                s_d.mode = MODE_CLOCK;
            end
            default: begin
                s_d.mode = MODE_HOLD;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{data: DATA_RST[WIDTH-1:0], clk_prev: CLK_PREV_RST, mode: MODE_HOLD};
        end else begin
            s_q <= s_d;
        end
    end

    assign data_q = s_q.data;
    assign mode = s_q.mode;
endmodule // xfer_lane

//--- test/bus_side_model.sv
// Far-side bus model: bench drivers, device drivers and bus hold on A and B
`timescale 1ns/100ps
module bus_side_model #(
    parameter int WIDTH = 18
) (
    input wire logic [WIDTH-1:0] a_out,
    input wire logic [WIDTH-1:0] a_oe,
    input wire logic [WIDTH-1:0] a_keep,
    input wire logic [WIDTH-1:0] a_drv,
    input wire logic a_en,
    input wire logic [WIDTH-1:0] b_out,
    input wire logic [WIDTH-1:0] b_oe,
    input wire logic [WIDTH-1:0] b_keep,
    input wire logic [WIDTH-1:0] b_drv,
    input wire logic b_en,
    output logic [WIDTH-1:0] a_in,
    output logic [WIDTH-1:0] b_in
);
    // Device drive wins, then the far-side driver, else the keeper level
    assign a_in = (a_oe & a_out) | (~a_oe & (a_en ? a_drv : a_keep));
    assign b_in = (b_oe & b_out) | (~b_oe & (b_en ? b_drv : b_keep));
endmodule // bus_side_model

//--- test/tb_top.sv
// Self-checking bench for the bus transceiver
`timescale 1ns/100ps
module tb_top;
    import xcvr_pkg::*;
    localparam int W = DATA_W;
    localparam logic [W-1:0] ONES = '1;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_W-1:0] pwdata = 32'h0;
    logic [APB_W-1:0] prdata, rd, seed;
    logic pready, pslverr, err;
    logic [W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe, a_keep, b_keep, v;
    logic [W-1:0] a_drv = 18'h00000;
    logic [W-1:0] b_drv = 18'h00000;
    logic [W-1:0] q [5];
    logic a_en = 1'b1;
    logic b_en = 1'b1;
    logic ab_oe = 1'b0;
    logic ab_le = 1'b0;
    logic ab_ck = 1'b0;
    logic ba_oen = 1'b1;
    logic ba_le = 1'b0;
    logic ba_ck = 1'b0;
    int fail_count = 0;
    int checked = 0;

    bus_transceiver #(.WIDTH(W), .LOG_DEPTH(FIFO_DEPTH)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in),
        .b_out(b_out), .b_oe(b_oe), .a_to_b_output_enable(ab_oe),
        .a_to_b_latch_enable(ab_le), .a_to_b_clock(ab_ck),
        .b_to_a_output_enable_n(ba_oen), .b_to_a_latch_enable(ba_le),
        .b_to_a_clock(ba_ck), .a_keep(a_keep), .b_keep(b_keep)
    );

    bus_side_model #(.WIDTH(W)) far_side (
        .a_out(a_out), .a_oe(a_oe), .a_keep(a_keep), .a_drv(a_drv), .a_en(a_en),
        .b_out(b_out), .b_oe(b_oe), .b_keep(b_keep), .b_drv(b_drv), .b_en(b_en),
        .a_in(a_in), .b_in(b_in)
    );

    initial begin
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] logword(input logic d, input logic [W-1:0] x);
        return {1'b1, 12'h000, d, x};
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic nxt();
        seed = lfsr(seed);
        v = seed[W-1:0];
    endtask

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        logic ok;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            fail_count++;
            results();
        end
    endtask

    task automatic set_dir(input logic d, input logic le);
        ab_oe <= !d;
        ba_oen <= !d;
        ab_le <= le && !d;
        ba_le <= le && d;
    endtask

    // Clock edge in one direction, with the clock low for one sampled cycle first
    task automatic rise(input logic d, input logic [W-1:0] x);
        a_drv <= x;
        b_drv <= x;
        ab_ck <= d ? ab_ck : 1'b0;
        ba_ck <= d ? 1'b0 : ba_ck;
        cyc(1);
        ab_ck <= ab_ck | !d;
        ba_ck <= ba_ck | d;
        cyc(2);
    endtask

    task automatic see(input logic d, input logic [W-1:0] e);
        chk(d ? "a_out" : "b_out", 32'(e), 32'(d ? a_out : b_out));
    endtask

    initial begin
        seed = 32'h24fd;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h220, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped", 32'h0, rd);
        apb(1'b1, 8'h14, 32'h3);
        chk("slverr", 32'h1, 32'(err));
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", 32'h0, rd);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            set_dir(i[0], 1'b1);
            nxt();
            a_drv <= v;
            b_drv <= v;
            cyc(3);
            see(i[0], v);
            chk("b_oe", 32'(i[0] ? '0 : ONES), 32'(b_oe));
            chk("a_oe", 32'(i[0] ? ONES : '0), 32'(a_oe));
        end
        $display("transparent test done");
        for (int i = 0; i < 8; i++) begin
            set_dir(i[0], 1'b0);
            nxt();
            rise(i[0], v);
            see(i[0], v);
            a_drv <= ~v;
            b_drv <= ~v;
            cyc(3);
            see(i[0], v);
        end
        $display("clocked test done");
        set_dir(1'b0, 1'b1);
        ab_ck <= 1'b1;
        nxt();
        a_drv <= v;
        cyc(3);
        ab_le <= 1'b0;
        cyc(2);
        a_drv <= ~v;
        cyc(3);
        see(1'b0, v);
        ab_oe <= 1'b0;
        nxt();
        rise(1'b0, v);
        chk("b_oe", 32'h0, 32'(b_oe));
        see(1'b0, v);
        apb(1'b0, HELD_AB_OFS, 32'h0);
        chk("held_ab", 32'(v), rd);
        a_en <= 1'b0;
        b_en <= 1'b0;
        cyc(4);
        chk("a_keep", 32'(v), 32'(a_keep));
        chk("b_keep", 32'(v), 32'(b_keep));
        a_en <= 1'b1;
        b_en <= 1'b1;
        ab_le <= 1'b1;
        nxt();
        a_drv <= v;
        cyc(3);
        ab_le <= 1'b0;
        apb(1'b0, HELD_AB_OFS, 32'h0);
        chk("held_ab", 32'(v), rd);
        $display("enable and hold test done");
        apb(1'b1, CTRL_OFS, 32'h1);
        for (int i = 0; i < 5; i++) begin
            nxt();
            q[i] = v;
            rise(1'b0, v);
        end
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h223, rd);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, LOG_OFS, 32'h0);
            chk("log", i < 4 ? logword(DIR_AB, q[i]) : 32'h0, rd);
        end
        apb(1'b1, STATUS_OFS, 32'h2);
        apb(1'b1, CTRL_OFS, 32'h2);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", 32'h2, rd);
        set_dir(1'b1, 1'b0);
        nxt();
        rise(1'b1, v);
        apb(1'b0, LOG_OFS, 32'h0);
        chk("log", logword(DIR_BA, v), rd);
        set_dir(1'b0, 1'b1);
        cyc(3);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h210, rd);
        $display("log test done");
        results();
    end

    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule // tb_top
